// File: core/uct_engine.sv
// Count engine: 16-bit down counter shared by timer and counter modes
`timescale 1ns/10ps
module uct_engine (
   input wire logic clk_i,
   input wire logic rst_b_i,
   input wire uct_pkg::uct_ctl_t ctl_i,
   input wire logic [15:0] preset_i,
   output logic [15:0] count_o,
   output logic level_o,
   output logic ready_set_o
);
   import uct_pkg::*;

   uct_run_t state_q, state_d;
   logic [15:0] count_q, count_d;
   logic wave_q, wave_d;
   logic zero_q, zero_d;

   wire step = (state_q == UCT_RUN) && ctl_i.tick;
   wire at_end = (count_q == UCT_COUNT_LAST);
   wire halt = ctl_i.stop && !ctl_i.timer;
   wire [15:0] count_dec = count_q - UCT_COUNT_ONE;

   // A start always wins: it abandons the cycle in progress
   assign state_d = ctl_i.start ? UCT_RUN : (halt ? UCT_IDLE : state_q);
   assign count_d = ctl_i.start ? preset_i :
                    (halt || !step) ? count_q :
                    (ctl_i.timer && at_end) ? preset_i : count_dec;
   assign wave_d = ctl_i.start ? 1'b1 :
                   (step && ctl_i.timer && at_end) ? !wave_q : wave_q;
   assign zero_d = (ctl_i.start || halt) ? 1'b0 :
                   (step && !ctl_i.timer && at_end) ? 1'b1 : zero_q;
   // Timer flags once per full wave: only when the low half ends
   assign ready_set_o = step && at_end && !ctl_i.start && !halt &&
                        (!ctl_i.timer || !wave_q);
   assign level_o = ctl_i.timer ? wave_q : !zero_q;
   assign count_o = count_q;

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         state_q <= UCT_IDLE;
         count_q <= UCT_COUNT_RST;
         wave_q <= 1'b1;
         zero_q <= 1'b0;
      end else begin
         state_q <= state_d;
         count_q <= count_d;
         wave_q <= wave_d;
         zero_q <= zero_d;
      end
   end

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_b_i);

   sequence s_start;
      ctl_i.start;
   endsequence

   a_start_loads: assert property (s_start |=> count_q == $past(preset_i) && state_q == UCT_RUN)
      else $error("start did not load preset");
   a_half_toggle: assert property (step && ctl_i.timer && at_end && !ctl_i.start
      |=> wave_q != $past(wave_q) && count_q == $past(preset_i))
      else $error("half period end did not toggle and reload");
   a_idle_holds: assert property (state_q == UCT_IDLE && !ctl_i.start |=> count_q == $past(count_q))
      else $error("idle counter moved");
   a_counter_stop: assert property (halt && !ctl_i.start |=> state_q == UCT_IDLE && level_o)
      else $error("stop did not halt counter or raise output");
   a_counter_past: assert property (step && !ctl_i.timer && !halt && !ctl_i.start
      |=> count_q == $past(count_dec) && state_q == UCT_RUN)
      else $error("counter did not keep decrementing");
endmodule

// File: core/uct_pkg.sv
// Shared constants and types for the counter/timer and output port block
package uct_pkg;

   // Register addresses on the 4-bit address lines
   localparam logic [3:0] UCT_ADDR_AUX_CTRL = 4'h4;
   localparam logic [3:0] UCT_ADDR_IRQ_STATUS = 4'h5;
   localparam logic [3:0] UCT_ADDR_PRESET_HIGH = 4'h6;
   localparam logic [3:0] UCT_ADDR_PRESET_LOW = 4'h7;
   localparam logic [3:0] UCT_ADDR_OUT_CFG = 4'hD;
   localparam logic [3:0] UCT_ADDR_CMD_START = 4'hE;
   localparam logic [3:0] UCT_ADDR_CMD_STOP = 4'hF;
   localparam logic [3:0] UCT_ADDR_LATCH_SET = 4'hE;
   localparam logic [3:0] UCT_ADDR_LATCH_CLEAR = 4'hF;

   // Field positions
   localparam int UCT_AUX_MODE_LSB = 4;
   localparam int UCT_AUX_MODE_MSB = 6;
   localparam int UCT_MODE_TIMER_BIT = 2;
   localparam int UCT_STATUS_READY_BIT = 3;
   localparam int UCT_OUT_CFG_PIN3_LSB = 2;
   localparam int UCT_OUT_CFG_PIN3_MSB = 3;
   localparam int UCT_PIN_THREE = 3;

   // Field values
   localparam logic [1:0] UCT_PIN3_SRC_CT = 2'h1;
   localparam logic [15:0] UCT_PRESET_MIN = 16'h0002;
   localparam logic [15:0] UCT_COUNT_LAST = 16'h0001;
   localparam logic [15:0] UCT_COUNT_ONE = 16'h0001;
   localparam logic [3:0] UCT_DIV16_LAST = 4'hF;
   localparam logic [3:0] UCT_DIV16_ONE = 4'h1;

   // Reset values
   localparam logic [7:0] UCT_AUX_CTRL_RST = 8'h00;
   localparam logic [7:0] UCT_OUT_CFG_RST = 8'h00;
   localparam logic [7:0] UCT_LATCH_RST = 8'h00;
   localparam logic [7:0] UCT_BYTE_ZERO = 8'h00;
   localparam logic [15:0] UCT_PRESET_RST = 16'h0002;
   localparam logic [15:0] UCT_COUNT_RST = 16'h0000;
   localparam logic [3:0] UCT_DIV_RST = 4'h0;
   localparam logic [7:0] UCT_PINS_RST = 8'hFF;

   // Host bus pins as sampled
   typedef struct packed {
      logic cs_b;
      logic rd_b;
      logic wr_b;
      logic [3:0] addr;
      logic [7:0] data;
   } uct_bus_t;

   // Controls passed to the count engine
   typedef struct packed {
      logic start;
      logic stop;
      logic timer;
      logic tick;
   } uct_ctl_t;

   typedef enum logic {
      UCT_IDLE = 1'b0,
      UCT_RUN = 1'b1
   } uct_run_t;

endpackage

// File: core/uct_top.sv
// Counter/timer with output port latch, reached over the host parallel bus
`timescale 1ns/10ps
// Summary of operation
// - Preset is high byte register over low byte register, sixteen bits total.
// - Preset registers are write-only; reads never return the preset.
// - Timer mode square wave period is twice the preset in timer clocks.
// - Idle until a start command: a read at address 1110.
// - After first start, timer mode runs on without further commands.
// - Each start abandons the current cycle and reloads from the preset.
// - Timer preset change waits for the current half period to end.
// - Timer sets ready once per wave; stop read clears it, timer keeps running.
// - Pin three carries the timer wave when selected as counter output.
// - Counter mode decrements from the preset only after a start.
// - Counter reaching zero sets the ready bit.
// - Counter keeps decrementing past zero until stopped.
// - Counter pin three high until zero then low; stop restores high.
// - Counter takes a new preset only at the next start.
// - Host may read the live count bytes; stop first to avoid carries.
// - Source config picks pins two to seven; pins zero and one elsewhere. Here only the pin three field is decoded; all other pins follow the latch.
// - A pin sourced by the latch shows the inverted latch bit.
// - Set and clear commands touch only latch bits given as ones.
// - Three-bit mode field: bit two set means timer, else counter.
module uct_top (
   input wire logic clk_i,
   input wire logic rst_b_i,
   input wire uct_pkg::uct_bus_t bus_i,
   output logic [7:0] data_o,
   output logic data_oe_o,
   output logic [7:0] out_pins_o
);
   import uct_pkg::*;

   // Bus pins are asynchronous to clk_i: two flops, then a history stage
   uct_bus_t sync1_q, sync2_q, hist_q;

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         sync1_q <= '1;
         sync2_q <= '1;
         hist_q <= '1;
      end else begin
         sync1_q <= bus_i;
         sync2_q <= sync1_q;
         hist_q <= sync2_q;
      end
   end

   // Access decode on the leading edge of a strobe
   wire rd_now = !sync2_q.cs_b && !sync2_q.rd_b;
   wire rd_was = !hist_q.cs_b && !hist_q.rd_b;
   wire wr_now = !sync2_q.cs_b && !sync2_q.wr_b;
   wire wr_was = !hist_q.cs_b && !hist_q.wr_b;
   wire rd_go = rd_now && !rd_was;
   wire wr_go = wr_now && !wr_was;
   wire [3:0] addr = sync2_q.addr;
   wire [7:0] wdata = sync2_q.data;

   wire cmd_start = rd_go && (addr == UCT_ADDR_CMD_START);
   wire cmd_stop = rd_go && (addr == UCT_ADDR_CMD_STOP);
   wire wr_aux = wr_go && (addr == UCT_ADDR_AUX_CTRL);
   wire wr_pre_hi = wr_go && (addr == UCT_ADDR_PRESET_HIGH);
   wire wr_pre_lo = wr_go && (addr == UCT_ADDR_PRESET_LOW);
   wire wr_out_cfg = wr_go && (addr == UCT_ADDR_OUT_CFG);
   wire wr_set = wr_go && (addr == UCT_ADDR_LATCH_SET);
   wire wr_clear = wr_go && (addr == UCT_ADDR_LATCH_CLEAR);

   // Software-visible registers
   logic [7:0] aux_q, aux_d;
   logic [7:0] pre_hi_q, pre_hi_d;
   logic [7:0] pre_lo_q, pre_lo_d;
   logic [7:0] out_cfg_q, out_cfg_d;
   logic [7:0] latch_q, latch_d;
   logic ready_q, ready_d;

   assign aux_d = wr_aux ? wdata : aux_q;
   assign pre_hi_d = wr_pre_hi ? wdata : pre_hi_q;
   assign pre_lo_d = wr_pre_lo ? wdata : pre_lo_q;
   assign out_cfg_d = wr_out_cfg ? wdata : out_cfg_q;

   // Set and clear live at different addresses, so they never collide
   assign latch_d = wr_set ? (latch_q | wdata) :
                    wr_clear ? (latch_q & ~wdata) : latch_q;

   wire [15:0] preset = {pre_hi_q, pre_lo_q};

   // Mode field: bit 2 picks timer, 010 is reserved and runs as counter
   wire [2:0] mode = aux_q[UCT_AUX_MODE_MSB:UCT_AUX_MODE_LSB];
   wire timer_mode = mode[UCT_MODE_TIMER_BIT];
   // Codes 011, 101 and 111 divide by sixteen; external sources are not
   // brought into this block, so every other code counts clk_i directly
   wire div16_sel = mode[0] && (mode[1] || mode[2]);

   logic [3:0] div_q, div_d;
   assign div_d = div_q + UCT_DIV16_ONE;
   wire tick = div16_sel ? (div_q == UCT_DIV16_LAST) : 1'b1;

   uct_ctl_t ctl;
   assign ctl.start = cmd_start;
   assign ctl.stop = cmd_stop;
   assign ctl.timer = timer_mode;
   assign ctl.tick = tick;

   logic [15:0] live_count;
   logic ct_level;
   logic ready_set;

   uct_engine u_engine (
      .clk_i(clk_i),
      .rst_b_i(rst_b_i),
      .ctl_i(ctl),
      .preset_i(preset),
      .count_o(live_count),
      .level_o(ct_level),
      .ready_set_o(ready_set)
   );

   // A timer terminal event in the same cycle as a stop keeps the flag set
   assign ready_d = ready_set || (ready_q && !cmd_stop);

   // Read data: preset addresses return the live count, never the preset
   logic [7:0] rd_mux;
   assign rd_mux = (addr == UCT_ADDR_PRESET_HIGH) ? live_count[15:8] :
                   (addr == UCT_ADDR_PRESET_LOW) ? live_count[7:0] :
                   (addr == UCT_ADDR_IRQ_STATUS) ?
                      (UCT_BYTE_ZERO | ({7'h00, ready_q} << UCT_STATUS_READY_BIT)) :
                   UCT_BYTE_ZERO;

   logic [7:0] data_q, data_d;
   logic oe_q;
   assign data_d = rd_go ? rd_mux : data_q;

   // Output pins: latch bits show inverted; pin three may carry the timer
   wire pin3_ct = (out_cfg_q[UCT_OUT_CFG_PIN3_MSB:UCT_OUT_CFG_PIN3_LSB] == UCT_PIN3_SRC_CT);
   logic [7:0] pins_d;
   logic [7:0] pins_q;

   // Pins zero and one would follow mode and command register sources;
   // those flow-control sources are not in this block, so the latch drives them
   genvar gi;
   generate
      for (gi = 0; gi < 8; gi++) begin : g_pin
         if (gi == UCT_PIN_THREE) begin : g_three
            assign pins_d[gi] = pin3_ct ? ct_level : !latch_q[gi];
         end else begin : g_plain
            assign pins_d[gi] = !latch_q[gi];
         end
      end
   endgenerate

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         aux_q <= UCT_AUX_CTRL_RST;
         pre_hi_q <= UCT_PRESET_RST[15:8];
         pre_lo_q <= UCT_PRESET_RST[7:0];
         out_cfg_q <= UCT_OUT_CFG_RST;
         latch_q <= UCT_LATCH_RST;
         ready_q <= 1'b0;
         div_q <= UCT_DIV_RST;
      end else begin
         aux_q <= aux_d;
         pre_hi_q <= pre_hi_d;
         pre_lo_q <= pre_lo_d;
         out_cfg_q <= out_cfg_d;
         latch_q <= latch_d;
         ready_q <= ready_d;
         div_q <= div_d;
      end
   end

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         data_q <= UCT_BYTE_ZERO;
         oe_q <= 1'b0;
         pins_q <= UCT_PINS_RST;
      end else begin
         data_q <= data_d;
         oe_q <= rd_now;
         pins_q <= pins_d;
      end
   end

   assign data_o = data_q;
   assign data_oe_o = oe_q;
   assign out_pins_o = pins_q;

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_b_i);

   sequence s_stop_alone;
      cmd_stop && !ready_set;
   endsequence

   sequence s_read_high;
      rd_go && (addr == UCT_ADDR_PRESET_HIGH);
   endsequence

   a_ready_set_wins: assert property (ready_set |=> ready_q)
      else $error("ready event lost");
   a_stop_clears_ready: assert property (s_stop_alone |=> !ready_q)
      else $error("stop did not clear ready");
   a_ready_holds: assert property (!ready_set && !cmd_stop |=> ready_q == $past(ready_q))
      else $error("ready changed without cause");
   a_preset_hidden: assert property (s_read_high |=> data_o == $past(live_count[15:8]))
      else $error("preset high read did not return live count");
   a_latch_set_bits: assert property (wr_set |=> latch_q == ($past(latch_q) | $past(wdata)))
      else $error("set command altered wrong latch bits");
   a_latch_clear_bits: assert property (wr_clear
      |=> latch_q == ($past(latch_q) & ~$past(wdata)))
      else $error("clear command altered wrong latch bits");
   a_pin_inverts: assert property (##1 out_pins_o[0] == !$past(latch_q[0]))
      else $error("latch pin not inverted");
   a_pin3_wave: assert property (pin3_ct |=> out_pins_o[UCT_PIN_THREE] == $past(ct_level))
      else $error("pin three does not follow counter output");
   a_start_decode: assert property (rd_go && addr == UCT_ADDR_CMD_START
      |=> live_count == $past(preset))
      else $error("start read did not restart count");
   a_preset_pair: assert property (wr_pre_hi |=> preset[15:8] == $past(wdata))
      else $error("high preset byte not stored");
endmodule

// File: sim/uct_host.sv
// Host CPU model: drives one register access at a time on the parallel bus
`timescale 1ns/10ps
module uct_host (
   input wire logic clk_i,
   input wire logic [7:0] data_i,
   output uct_pkg::uct_bus_t bus_o
);
   import uct_pkg::*;
   logic [7:0] last_q;
   initial begin
      last_q = 8'h00;
      bus_o = '{cs_b: 1'b1, rd_b: 1'b1, wr_b: 1'b1, addr: 4'h0, data: 8'hFF};
   end
   // Strobe is held four edges so the synced decode and the read data both land;
   // a released data line shows the inverse of its last value, never a held copy
   task automatic access(input logic rd, input logic [3:0] addr, input logic [7:0] wdata,
                         output logic [7:0] rdata);
      @(posedge clk_i);
      #1;
      bus_o.addr = addr;
      bus_o.data = rd ? ~last_q : wdata;
      bus_o.cs_b = 1'b0;
      bus_o.rd_b = ~rd;
      bus_o.wr_b = rd;
      repeat (4) @(posedge clk_i);
      #1;
      rdata = data_i;
      bus_o.cs_b = 1'b1;
      bus_o.rd_b = 1'b1;
      bus_o.wr_b = 1'b1;
      last_q = bus_o.data;
      bus_o.data = ~bus_o.data;
      // Recovery gap longer than the two cycles the bus needs between accesses
      repeat (3) @(posedge clk_i);
   endtask
endmodule

// File: sim/uct_top_bench.sv
// Self-checking bench for the counter/timer and output port block
`timescale 1ns/10ps
module uct_top_bench;
   import uct_pkg::*;
   logic clk_i = 1'b0;
   logic rst_b_i = 1'b0;
   uct_bus_t bus;
   logic [7:0] data;
   logic data_oe;
   logic [7:0] pins;
   logic [7:0] v1;
   logic [7:0] v2;
   int miscompares = 0;
   int checks = 0;
   int hi;
   int per;
   uct_top dut_u (.clk_i(clk_i), .rst_b_i(rst_b_i), .bus_i(bus), .data_o(data),
                  .data_oe_o(data_oe), .out_pins_o(pins));
   uct_host host_u (.clk_i(clk_i), .data_i(data), .bus_o(bus));
   initial begin
      forever #2.5 clk_i = ~clk_i;
   end
   task automatic finish_test;
      if (miscompares == 0 && checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
      checks++;
      if (got !== exp) begin
         miscompares++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      logic [7:0] r;
      host_u.access(1'b0, a, d, r);
   endtask
   task automatic rdv(input logic [3:0] a, output logic [7:0] r);
      host_u.access(1'b1, a, 8'h00, r);
   endtask
   // The enable is sampled one edge before the read data is taken, while the strobe stands
   task automatic rd(input logic [3:0] a, input logic [7:0] exp);
      logic [7:0] r;
      logic oe;
      oe = 1'b0;
      fork
         rdv(a, r);
         begin
            repeat (4) @(posedge clk_i);
            #1;
            oe = data_oe;
         end
      join
      cmp({8'h00, r}, {8'h00, exp});
      cmp({15'h0000, oe}, 16'h0001);
   endtask
   // Waits for a rising edge on pin three, then times one high half and one full wave
   task automatic wave(output int h, output int p);
      int n;
      n = 0;
      while (pins[3] !== 1'b0 && n < 400) begin
         @(posedge clk_i);
         #1;
         n++;
      end
      while (pins[3] !== 1'b1 && n < 800) begin
         @(posedge clk_i);
         #1;
         n++;
      end
      h = 0;
      while (pins[3] === 1'b1 && h < 400) begin
         @(posedge clk_i);
         #1;
         h++;
      end
      p = h;
      while (pins[3] === 1'b0 && p < 800) begin
         @(posedge clk_i);
         #1;
         p++;
      end
   endtask
   initial begin
      #20000;
      miscompares++;
      finish_test();
   end
   initial begin
      repeat (2) @(posedge clk_i);
      #1;
      rst_b_i = 1'b1;
      cmp({8'h00, pins}, 16'h00FF);
      rd(UCT_ADDR_IRQ_STATUS, 8'h00);
      wr(UCT_ADDR_PRESET_HIGH, 8'h12);
      wr(UCT_ADDR_PRESET_LOW, 8'h34);
      rd(UCT_ADDR_PRESET_HIGH, 8'h00);
      rd(UCT_ADDR_PRESET_LOW, 8'h00);
      wr(UCT_ADDR_LATCH_SET, 8'hA5);
      cmp({8'h00, pins}, 16'h005A);
      wr(UCT_ADDR_LATCH_CLEAR, 8'h05);
      cmp({8'h00, pins}, 16'h005F);
      wr(UCT_ADDR_LATCH_SET, 8'h08);
      cmp({8'h00, pins}, 16'h0057);
      // Counter mode, preset 0x0010, pin three given to the counter
      wr(UCT_ADDR_OUT_CFG, 8'h04);
      wr(UCT_ADDR_PRESET_HIGH, 8'h00);
      wr(UCT_ADDR_PRESET_LOW, 8'h10);
      repeat (30) @(posedge clk_i);
      rd(UCT_ADDR_IRQ_STATUS, 8'h00);
      rd(UCT_ADDR_CMD_START, 8'h00);
      cmp({8'h00, pins}, 16'h005F);
      rd(UCT_ADDR_IRQ_STATUS, 8'h00);
      repeat (20) @(posedge clk_i);
      rd(UCT_ADDR_IRQ_STATUS, 8'h08);
      cmp({8'h00, pins}, 16'h0057);
      rd(UCT_ADDR_PRESET_HIGH, 8'hFF);
      rd(UCT_ADDR_CMD_STOP, 8'h00);
      cmp({8'h00, pins}, 16'h005F);
      rd(UCT_ADDR_IRQ_STATUS, 8'h00);
      rdv(UCT_ADDR_PRESET_LOW, v1);
      rdv(UCT_ADDR_PRESET_LOW, v2);
      cmp({8'h00, v2}, {8'h00, v1});
      wr(UCT_ADDR_PRESET_HIGH, 8'h03);
      wr(UCT_ADDR_PRESET_LOW, 8'h80);
      rd(UCT_ADDR_PRESET_HIGH, 8'hFF);
      rd(UCT_ADDR_CMD_START, 8'h00);
      rd(UCT_ADDR_PRESET_HIGH, 8'h03);
      rd(UCT_ADDR_CMD_STOP, 8'h00);
      // Timer mode on clk_i, half period 0x40
      wr(UCT_ADDR_AUX_CTRL, 8'h60);
      wr(UCT_ADDR_PRESET_LOW, 8'h40);
      wr(UCT_ADDR_PRESET_HIGH, 8'h00);
      rd(UCT_ADDR_CMD_START, 8'h00);
      wave(hi, per);
      cmp(16'(hi), 16'd64);
      cmp(16'(per), 16'd128);
      rd(UCT_ADDR_IRQ_STATUS, 8'h08);
      rd(UCT_ADDR_CMD_STOP, 8'h00);
      rd(UCT_ADDR_IRQ_STATUS, 8'h00);
      wave(hi, per);
      cmp(16'(per), 16'd128);
      wr(UCT_ADDR_PRESET_LOW, 8'h20);
      wave(hi, per);
      cmp(16'(hi), 16'd32);
      cmp(16'(per), 16'd64);
      cmp({8'h00, pins & 8'hF7}, 16'h0057);
      // Timer on clk_i divided by sixteen, preset 0x0002: half period 32 clocks
      wr(UCT_ADDR_AUX_CTRL, 8'h70);
      wr(UCT_ADDR_PRESET_LOW, 8'h02);
      rd(UCT_ADDR_CMD_START, 8'h00);
      wave(hi, per);
      cmp(16'(hi), 16'd32);
      cmp(16'(per), 16'd64);
      finish_test();
   end
endmodule
